// ---- dv/nvm_model.sv ----
`timescale 1ns/1ns
module nvm_model(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic nvm_req,
	input wire logic [15:0] word,
	input wire logic [3:0] dly,
	output logic nvm_ack,
	output logic [15:0] nvm_rdata
);
	logic [3:0] wait_r;
	// Idle data toggles so a stale word is never mistaken for a fresh one
	initial nvm_rdata = 16'h5A5A;
	always @(posedge clk) begin
		if (!rst_b || !nvm_req || nvm_ack) begin
			wait_r <= 4'h0;
			nvm_ack <= 1'b0;
			nvm_rdata <= ~nvm_rdata;
		end else if (wait_r == dly) begin
			nvm_ack <= 1'b1;
			nvm_rdata <= word;
		end else begin
			wait_r <= wait_r + 4'h1;
			nvm_rdata <= ~nvm_rdata;
		end
	end
endmodule

// ---- dv/sdp_cfg_loader_sva.sv ----
`timescale 1ns/1ns
module sdp_cfg_loader_sva(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic nvm_req,
	input wire logic nvm_ack,
	input wire logic [7:0] nvm_addr,
	input wire logic [15:0] nvm_rdata,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic two_wire_on_pins_enable,
	input wire logic port_off_phy_powerdown,
	input wire logic low_power_speed_limit,
	input wire logic giga_disable,
	input wire logic load_done
);
	logic [15:0] w;
	always_ff @(posedge clk) if (nvm_req && nvm_ack) w <= nvm_rdata;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_fetch_addr: assert property (nvm_req |-> nvm_addr == 8'h20) else $error("addr");
	a_load_two: assert property (nvm_req && nvm_ack |-> ##2 $rose(load_done)) else $error("late");
	a_dir_load: assert property ($rose(load_done) && !w[10] && !w[5] |-> pin_oe == {w[15:14], w[9:8]})
		else $error("dir");
	a_data_load: assert property ($rose(load_done) |-> (pin_out & pin_oe & {3'h7, !w[5]}) ==
		({w[7:6], w[1:0]} & pin_oe & {3'h7, !w[5]})) else $error("data");
	a_ctl_load: assert property ($rose(load_done) |->
		{giga_disable, low_power_speed_limit, port_off_phy_powerdown} == {w[4], w[12], w[13]}) else $error("ctl");
	a_two_wire: assert property ($rose(load_done) |-> two_wire_on_pins_enable == w[10] &&
		!(w[10] && (pin_oe[0] || pin_oe[2]))) else $error("2w");
	a_wd_pin0: assert property ($rose(load_done) && w[5] && !w[10] |-> pin_oe[0]) else $error("wd");
	a_no_early: assert property (!load_done |-> pin_oe == 4'h0) else $error("early");
endmodule
bind sdp_init_config_loader sdp_cfg_loader_sva i_sdp_cfg_loader_sva(.*);

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top import sdp_cfg_pkg::*;;
	logic clk = 0;
	logic rst_b = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic wdog_timeout = 1;
	logic se;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pin_in = 4'h5;
	logic [15:0] word = 16'h0000;
	logic [3:0] dly = 4'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, nvm_req, nvm_ack, two_wire_on_pins_enable, port_off_phy_powerdown;
	logic low_power_speed_limit, giga_disable, load_done;
	logic [7:0] nvm_addr;
	logic [15:0] nvm_rdata;
	logic [3:0] pin_out, pin_oe;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	sdp_init_config_loader i_sdp_init_config_loader(.*);
	nvm_model i_nvm_model(.*);
	task automatic give_verdict;
		if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			give_verdict;
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// Entered just after a rising edge; response is taken at the completing edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		se = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic run(input logic [15:0] w, input logic [3:0] d);
		word <= w;
		dly <= d;
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		apb(0, A_DEV_CTRL, 0);
		chk("dev", {26'h0, w[5], 1'b0, w[1:0], w[9:8]}, rd);
		apb(0, A_EXT_CTRL, 0);
		chk("ext", {27'h0, w[10], w[7:6], w[15:14]}, rd);
		apb(0, A_PWR_CTRL, 0);
		chk("pwr", {29'h0, w[4], w[12], w[13]}, rd);
		apb(0, A_STATUS, 0);
		chk("stat", 32'h0000_0015, rd);
		chk("oe", {w[15], !w[10] && w[14], w[9], !w[10] && (w[5] || w[8])}, pin_oe);
		chk("out", {w[7:6], w[1], w[5] | w[0]} & pin_oe, pin_out & pin_oe);
		chk("addr", 8'h20, nvm_addr);
	endtask
	initial begin
		run(16'hC3C3, 4'h0);
		run(16'h3834, 4'h5);
		run(16'h0400, 4'h2);
		apb(1, A_PWR_CTRL, 32'h0000_0007);
		apb(0, A_PWR_CTRL, 0);
		chk("wr", 32'h0000_0007, rd);
		chk("gd", 1'b1, giga_disable);
		apb(0, 12'h040, 0);
		chk("unm", 1'b1, se);
		give_verdict;
	end
endmodule

// ---- src/nvm_word_fetch.sv ----
`timescale 1ns/1ns
module nvm_word_fetch import sdp_cfg_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	output logic nvm_req,
	output logic [7:0] nvm_addr,
	input wire logic nvm_ack,
	input wire logic [15:0] nvm_rdata,
	output logic [15:0] word_r,
	output logic done
);
	typedef enum logic [1:0] {F_IDLE, F_WAIT, F_DONE} fetch_e;
	fetch_e st_r;
	fetch_e st_nxt;
	logic [15:0] word_nxt;

	assign nvm_addr = NVM_PIN_WORD_OFS;
	assign nvm_req = (st_r == F_WAIT);
	assign done = (st_r == F_DONE);

	always_comb begin
		st_nxt = st_r;
		word_nxt = word_r;
		case (st_r)
			F_IDLE: st_nxt = F_WAIT;
			F_WAIT: begin
				if (nvm_ack) begin
					word_nxt = nvm_rdata;
					st_nxt = F_DONE;
				end
			end
			default: st_nxt = F_DONE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= F_IDLE;
			word_r <= NVM_WORD_RST;
		end else begin
			st_r <= st_nxt;
			word_r <= word_nxt;
		end
	end
endmodule

// ---- src/sdp_cfg_pkg.sv ----
// Overview of operation
// - At power-up fetch the pin setup word from offset 0x20 of the nvm section.
// - Word bits 15,14 load pin 3 and pin 2 direction bits of extended control.
// - Word bits 9,8 load pin 1 and pin 0 direction bits of device control.
// - Word bits 7,6 load pin 3,2 data bits; output pins drive them.
// - Word bits 1,0 load pin 1,0 data bits; output pins drive them.
// - Bit 13 zero keeps MAC and PHY alive when port off; one powers down.
// - Bit 12 sets low-power speed limit default, forbidding 1000 and 100 outside active state.
// - Bit 10 sets two-wire-on-pins default; pins 0 and 2 become two-wire lines.
// - Bit 5 set puts watchdog timeout on pin 0 unless bit 10 is set; clear leaves ordinary pin.
// - Bit 4 set disables gigabit operation entirely.
package sdp_cfg_pkg;
	localparam logic [7:0] NVM_PIN_WORD_OFS = 8'h20;
	localparam int B_DIR3 = 15;
	localparam int B_DIR2 = 14;
	localparam int B_PORT_OFF_PD = 13;
	localparam int B_LP_LIMIT = 12;
	localparam int B_TWO_WIRE = 10;
	localparam int B_DIR1 = 9;
	localparam int B_DIR0 = 8;
	localparam int B_VAL3 = 7;
	localparam int B_VAL2 = 6;
	localparam int B_WD_PIN0 = 5;
	localparam int B_GIGA_OFF = 4;
	localparam int B_VAL1 = 1;
	localparam int B_VAL0 = 0;
	// APB byte addresses of the control registers
	localparam logic [11:0] A_DEV_CTRL = 12'h000;
	localparam logic [11:0] A_EXT_CTRL = 12'h004;
	localparam logic [11:0] A_PWR_CTRL = 12'h008;
	localparam logic [11:0] A_STATUS = 12'h00C;
	localparam logic [11:0] A_NVM_WORD = 12'h080;
	// Bit positions in the device and extended control registers
	localparam int R_DIR_LO = 0;
	localparam int R_DATA_LO = 2;
	localparam int R_TWO_WIRE = 4;
	localparam int R_WD_PIN0 = 5;
	// Power control register bits
	localparam int R_PORT_OFF_PD = 0;
	localparam int R_LP_LIMIT = 1;
	localparam int R_GIGA_OFF = 2;
	localparam logic [15:0] NVM_WORD_RST = 16'h0000;

	typedef struct packed {
		logic [1:0] dir;
		logic [1:0] data;
	} pin_pair_s;

	typedef struct packed {
		pin_pair_s lo;
		pin_pair_s hi;
		logic two_wire;
		logic wd_pin0;
		logic port_off_pd;
		logic lp_limit;
		logic giga_off;
	} cfg_s;
endpackage

// ---- src/sdp_init_config_loader.sv ----
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module sdp_init_config_loader import sdp_cfg_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic nvm_req,
	output logic [7:0] nvm_addr,
	input wire logic nvm_ack,
	input wire logic [15:0] nvm_rdata,
	input wire logic wdog_timeout,
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	output logic two_wire_on_pins_enable,
	output logic port_off_phy_powerdown,
	output logic low_power_speed_limit,
	output logic giga_disable,
	output logic load_done
);
	logic [15:0] word;
	logic fetched;
	cfg_s cfg_r;
	cfg_s cfg_nxt;
	logic done_r;
	logic [3:0] pin_s1_r;
	logic [3:0] pin_s2_r;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic rd_valid_r;

	nvm_word_fetch u_fetch (
		.clk(clk),
		.rst_b(rst_b),
		.nvm_req(nvm_req),
		.nvm_addr(nvm_addr),
		.nvm_ack(nvm_ack),
		.nvm_rdata(nvm_rdata),
		.word_r(word),
		.done(fetched)
	);

	wire wr = psel && penable && pwrite && done_r;
	wire rd = psel && penable && !pwrite;
	wire sel_dev = (paddr == A_DEV_CTRL);
	wire sel_ext = (paddr == A_EXT_CTRL);
	wire sel_pwr = (paddr == A_PWR_CTRL);
	wire sel_sta = (paddr == A_STATUS);
	wire sel_nvm = (paddr == A_NVM_WORD);
	wire mapped = sel_dev || sel_ext || sel_pwr || sel_sta || sel_nvm;
	wire load = fetched && !done_r;

	// Bus stalls until the word is loaded so software never sees pre-load values
	// Reads take one wait state so registered read data stands at the completing edge
	assign pready = done_r && (pwrite || rd_valid_r);
	assign pslverr = psel && penable && pready && (!mapped || (pwrite && (sel_sta || sel_nvm)));
	assign prdata = prdata_r;
	assign load_done = done_r;

	always_comb begin
		cfg_nxt = cfg_r;
		if (load) begin
			cfg_nxt.hi.dir = {word[B_DIR3], word[B_DIR2]};
			cfg_nxt.lo.dir = {word[B_DIR1], word[B_DIR0]};
			cfg_nxt.hi.data = {word[B_VAL3], word[B_VAL2]};
			cfg_nxt.lo.data = {word[B_VAL1], word[B_VAL0]};
			cfg_nxt.port_off_pd = word[B_PORT_OFF_PD];
			cfg_nxt.lp_limit = word[B_LP_LIMIT];
			cfg_nxt.two_wire = word[B_TWO_WIRE];
			cfg_nxt.wd_pin0 = word[B_WD_PIN0];
			cfg_nxt.giga_off = word[B_GIGA_OFF];
			// Bit 11 is deliberately not referenced
		end else if (wr && sel_dev) begin
			cfg_nxt.lo.dir = pwdata[R_DIR_LO +: 2];
			cfg_nxt.lo.data = pwdata[R_DATA_LO +: 2];
			cfg_nxt.wd_pin0 = pwdata[R_WD_PIN0];
		end else if (wr && sel_ext) begin
			cfg_nxt.hi.dir = pwdata[R_DIR_LO +: 2];
			cfg_nxt.hi.data = pwdata[R_DATA_LO +: 2];
			cfg_nxt.two_wire = pwdata[R_TWO_WIRE];
		end else if (wr && sel_pwr) begin
			cfg_nxt.port_off_pd = pwdata[R_PORT_OFF_PD];
			cfg_nxt.lp_limit = pwdata[R_LP_LIMIT];
			cfg_nxt.giga_off = pwdata[R_GIGA_OFF];
		end
	end

	always_comb begin
		prdata_nxt = prdata_r;
		if (rd && done_r && !rd_valid_r) begin
			prdata_nxt = 32'h0000_0000;
			if (sel_dev) begin
				prdata_nxt[R_DIR_LO +: 2] = cfg_r.lo.dir;
				prdata_nxt[R_DATA_LO +: 2] = cfg_r.lo.data;
				prdata_nxt[R_WD_PIN0] = cfg_r.wd_pin0;
			end else if (sel_ext) begin
				prdata_nxt[R_DIR_LO +: 2] = cfg_r.hi.dir;
				prdata_nxt[R_DATA_LO +: 2] = cfg_r.hi.data;
				prdata_nxt[R_TWO_WIRE] = cfg_r.two_wire;
			end else if (sel_pwr) begin
				prdata_nxt[R_PORT_OFF_PD] = cfg_r.port_off_pd;
				prdata_nxt[R_LP_LIMIT] = cfg_r.lp_limit;
				prdata_nxt[R_GIGA_OFF] = cfg_r.giga_off;
			end else if (sel_sta) begin
				prdata_nxt[3:0] = pin_s2_r;
				prdata_nxt[4] = done_r;
			end else if (sel_nvm) begin
				prdata_nxt[15:0] = word;
			end
		end
	end

	// Pin drivers stay disabled until the load finishes, so no pre-load value escapes
	wire [1:0] lo_oe = done_r ? cfg_r.lo.dir : 2'b00;
	wire [1:0] hi_oe = done_r ? cfg_r.hi.dir : 2'b00;
	// Two-wire engine owns pins 0 and 2; its lines are left released here
	wire tw = cfg_r.two_wire;
	wire p0_oe = tw ? 1'b0 : (cfg_r.wd_pin0 ? done_r : lo_oe[0]);
	wire p0_out = cfg_r.wd_pin0 ? wdog_timeout : cfg_r.lo.data[0];

	assign pin_oe = {hi_oe[1], (tw ? 1'b0 : hi_oe[0]), lo_oe[1], p0_oe};
	assign pin_out = {cfg_r.hi.data[1], cfg_r.hi.data[0], cfg_r.lo.data[1], p0_out};
	assign two_wire_on_pins_enable = cfg_r.two_wire;
	assign port_off_phy_powerdown = cfg_r.port_off_pd;
	assign low_power_speed_limit = cfg_r.lp_limit;
	assign giga_disable = cfg_r.giga_off;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfg_r <= '0;
			done_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			rd_valid_r <= 1'b0;
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
		end else begin
			cfg_r <= cfg_nxt;
			done_r <= done_r || fetched;
			prdata_r <= prdata_nxt;
			rd_valid_r <= rd && done_r && !rd_valid_r;
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
		end
	end
endmodule
